// ---- core/dtc_top.sv ----
// Purpose: dual timer/counter, 8-bit up counter and 16-bit compare/capture/pwm counter
// Assumes: one clock, register port with read data one cycle after the strobe
// Notes: 16-bit registers are single accesses on the 16-bit data port
// Behaviour
// - narrow clock select: stop, CK, prescaled, pin edges
// - prescaled from oscillator clock; stop disables counter
// - count pins synchronised on rising clock edge
// - reserved control bits read zero
// - narrow counts up; resumes after write
// - narrow overflow flag with shared mask
// - wide overflow, compare, capture flags, masked
// - wide counter compared against A and B
// - compare pin: off, toggle, clear, set
// - pwm select: off, 8, 9, 10 bits
// - pwm: up/down, centered, glitch-free outputs
// - capture trigger copies counter into capture value
// - comparator output selectable as capture source
// - unfiltered capture on first sampled edge
// - filtered capture after four matching samples
// - wide clock select uses same encoding
// - edge select: zero falling, one rising
// - clear-on-match resets counter after match A, outside pwm only
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module dtc_top
  import dtc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic NARROW_COUNT_PIN_I,
  input wire logic WIDE_COUNT_PIN_I,
  input wire logic CAPTURE_INPUT_PIN_I,
  input wire logic COMPARATOR_OUTPUT_I,
  input wire logic COMPARATOR_CAPTURE_ENABLE_I,
  output logic COMPARE_OUT_PIN_A_O,
  output logic COMPARE_OUT_PIN_A_OE_O,
  output logic COMPARE_OUT_PIN_B_O,
  output logic COMPARE_OUT_PIN_B_OE_O,
  output logic [DTC_FLAG_W-1:0] TIMER_REQ_O
);
  logic [DTC_PRE_W-1:0] pre_reg;
  logic [7:0] narrow_ctrl_reg;
  logic [7:0] narrow_val_reg;
  logic [7:0] cmp_ctrl_reg;
  logic [7:0] cap_ctrl_reg;
  logic [15:0] wide_val_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] cmp_a_act_reg;
  logic [15:0] cmp_b_act_reg;
  logic [15:0] capture_reg;
  logic [DTC_FLAG_W-1:0] flag_reg;
  logic [DTC_FLAG_W-1:0] flag_next;
  logic [DTC_FLAG_W-1:0] mask_reg;
  logic [15:0] rdata_reg;
  logic out_a_reg;
  logic out_b_reg;
  dtc_dir_t dir_reg;
  logic wr_narrow_val;
  logic wr_wide_val;
  logic wr_flag;
  logic tick0;
  logic tick1;
  logic cap_trig;
  logic pwm_on;
  logic [15:0] top;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic match_a;
  logic match_b;
  logic clr_hit;
  logic at_top;
  logic narrow_ovf;
  logic wide_ovf;
  logic [15:0] wide_val_next;
  dtc_dir_t dir_next;

  // write decodes
  assign wr_narrow_val = REG_WR_I && (REG_ADDR_I == DTC_NARROW_VAL_OFS);
  assign wr_wide_val = REG_WR_I && (REG_ADDR_I == DTC_WIDE_VAL_OFS);
  assign wr_flag = REG_WR_I && (REG_ADDR_I == DTC_FLAG_OFS);

  // shared free running prescaler
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // per-counter tick selection
  dtc_clk_sel u_narrow_sel (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .sel_i(narrow_ctrl_reg[DTC_CS_HI:DTC_CS_LO]),
    .pre_i(pre_reg),
    .pin_i(NARROW_COUNT_PIN_I),
    .tick_o(tick0)
  );
  dtc_clk_sel u_wide_sel (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .sel_i(cap_ctrl_reg[DTC_CS_HI:DTC_CS_LO]),
    .pre_i(pre_reg),
    .pin_i(WIDE_COUNT_PIN_I),
    .tick_o(tick1)
  );

  // capture trigger source, filter and edge
  dtc_capture u_capture (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .pin_i(CAPTURE_INPUT_PIN_I),
    .acmp_i(COMPARATOR_OUTPUT_I),
    .acmp_sel_i(COMPARATOR_CAPTURE_ENABLE_I),
    .filt_i(cap_ctrl_reg[DTC_FILT_EN]),
    .edge_i(cap_ctrl_reg[DTC_EDGE_SEL]),
    .trig_o(cap_trig)
  );

  // control registers, reserved bits held at zero
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      narrow_ctrl_reg <= DTC_CTRL_RST;
      cmp_ctrl_reg <= DTC_CTRL_RST;
      cap_ctrl_reg <= DTC_CTRL_RST;
      mask_reg <= DTC_FLAG_RST;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        DTC_NARROW_CTRL_OFS: narrow_ctrl_reg <= REG_WDATA_I[7:0] & DTC_NARROW_CTRL_WMASK;
        DTC_CMP_CTRL_OFS: cmp_ctrl_reg <= REG_WDATA_I[7:0] & DTC_CMP_CTRL_WMASK;
        DTC_CAP_CTRL_OFS: cap_ctrl_reg <= REG_WDATA_I[7:0] & DTC_CAP_CTRL_WMASK;
        DTC_MASK_OFS: mask_reg <= REG_WDATA_I[DTC_FLAG_W-1:0];
        default: ;
      endcase
    end
  end

  // compare values as software wrote them
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cmp_a_reg <= DTC_VAL_RST;
      cmp_b_reg <= DTC_VAL_RST;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == DTC_CMP_A_OFS) begin
        cmp_a_reg <= REG_WDATA_I;
      end
      if (REG_ADDR_I == DTC_CMP_B_OFS) begin
        cmp_b_reg <= REG_WDATA_I;
      end
    end
  end

  // narrow counter: up only, a write wins over the tick
  assign narrow_ovf = tick0 && !wr_narrow_val && (narrow_val_reg == DTC_NARROW_MAX);
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      narrow_val_reg <= DTC_VAL_RST[7:0];
    end else if (wr_narrow_val) begin
      narrow_val_reg <= REG_WDATA_I[7:0];
    end else if (tick0) begin
      narrow_val_reg <= narrow_val_reg + 8'h01;
    end
  end

  // wide counter mode decode
  assign pwm_on = (cmp_ctrl_reg[DTC_PWM_HI:DTC_PWM_LO] != DTC_PWM_OFF);
  assign mode_a = cmp_ctrl_reg[DTC_MODE_A_HI:DTC_MODE_A_LO];
  assign mode_b = cmp_ctrl_reg[DTC_MODE_B_HI:DTC_MODE_B_LO];
  always_comb begin
    case (cmp_ctrl_reg[DTC_PWM_HI:DTC_PWM_LO])
      DTC_PWM_8: top = DTC_TOP_8;
      DTC_PWM_9: top = DTC_TOP_9;
      DTC_PWM_10: top = DTC_TOP_10;
      default: top = DTC_WIDE_MAX;
    endcase
  end

  // continuous compare, ten low bits in pwm mode
  always_comb begin
    if (pwm_on) begin
      match_a = tick1 && (wide_val_reg[9:0] == cmp_a_act_reg[9:0]);
      match_b = tick1 && (wide_val_reg[9:0] == cmp_b_act_reg[9:0]);
    end else begin
      match_a = tick1 && (wide_val_reg == cmp_a_act_reg);
      match_b = tick1 && (wide_val_reg == cmp_b_act_reg);
    end
  end
  assign clr_hit = !pwm_on && cap_ctrl_reg[DTC_CLR_ON_A] && match_a;
  assign at_top = wide_val_reg >= top;

  // wide counter next value and direction
  always_comb begin
    wide_val_next = wide_val_reg;
    dir_next = dir_reg;
    wide_ovf = 1'b0;
    if (wr_wide_val) begin
      wide_val_next = REG_WDATA_I;
    end else if (tick1) begin
      if (!pwm_on) begin
        dir_next = DTC_UP;
        if (clr_hit) begin
          wide_val_next = DTC_VAL_RST;
        end else begin
          wide_val_next = wide_val_reg + 16'h0001;
          wide_ovf = (wide_val_reg == DTC_WIDE_MAX);
        end
      end else begin
        case (dir_reg)
          DTC_UP: begin
            if (at_top) begin
              dir_next = DTC_DOWN;
              wide_val_next = wide_val_reg - 16'h0001;
            end else begin
              wide_val_next = wide_val_reg + 16'h0001;
            end
          end
          DTC_DOWN: begin
            if (wide_val_reg == DTC_VAL_RST) begin
              dir_next = DTC_UP;
              wide_val_next = 16'h0001;
              wide_ovf = 1'b1;
            end else begin
              wide_val_next = wide_val_reg - 16'h0001;
            end
          end
          default: begin
            dir_next = DTC_UP;
            wide_val_next = DTC_VAL_RST;
          end
        endcase
      end
    end
  end

  // wide counter state
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wide_val_reg <= DTC_VAL_RST;
      dir_reg <= DTC_UP;
    end else begin
      wide_val_reg <= wide_val_next;
      dir_reg <= dir_next;
    end
  end

  // active compare values: reloaded only at top in pwm so edges never glitch
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cmp_a_act_reg <= DTC_VAL_RST;
      cmp_b_act_reg <= DTC_VAL_RST;
    end else if (!pwm_on || (tick1 && at_top && dir_reg == DTC_UP)) begin
      cmp_a_act_reg <= cmp_a_reg;
      cmp_b_act_reg <= cmp_b_reg;
    end
  end

  // compare pin A action
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      out_a_reg <= 1'b0;
    end else if (match_a) begin
      if (pwm_on) begin
        if (mode_a[1]) begin
          out_a_reg <= (dir_reg == DTC_UP) ? mode_a[0] : ~mode_a[0];
        end
      end else begin
        case (mode_a)
          DTC_OM_TOGGLE: out_a_reg <= ~out_a_reg;
          DTC_OM_CLEAR: out_a_reg <= 1'b0;
          DTC_OM_SET: out_a_reg <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // compare pin B action
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      out_b_reg <= 1'b0;
    end else if (match_b) begin
      if (pwm_on) begin
        if (mode_b[1]) begin
          out_b_reg <= (dir_reg == DTC_UP) ? mode_b[0] : ~mode_b[0];
        end
      end else begin
        case (mode_b)
          DTC_OM_TOGGLE: out_b_reg <= ~out_b_reg;
          DTC_OM_CLEAR: out_b_reg <= 1'b0;
          DTC_OM_SET: out_b_reg <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // pins driven only while their mode connects them
  assign COMPARE_OUT_PIN_A_O = out_a_reg;
  assign COMPARE_OUT_PIN_B_O = out_b_reg;
  assign COMPARE_OUT_PIN_A_OE_O = pwm_on ? mode_a[1] : (mode_a != DTC_OM_OFF);
  assign COMPARE_OUT_PIN_B_OE_O = pwm_on ? mode_b[1] : (mode_b != DTC_OM_OFF);

  // capture value
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      capture_reg <= DTC_VAL_RST;
    end else if (cap_trig) begin
      capture_reg <= wide_val_reg;
    end
  end

  // sticky flags: write one clears, a new event wins over the clear
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag) begin
      flag_next = flag_reg & ~REG_WDATA_I[DTC_FLAG_W-1:0];
    end
    flag_next[DTC_F_NARROW_OVF] = flag_next[DTC_F_NARROW_OVF] | narrow_ovf;
    flag_next[DTC_F_WIDE_OVF] = flag_next[DTC_F_WIDE_OVF] | wide_ovf;
    flag_next[DTC_F_CMP_A] = flag_next[DTC_F_CMP_A] | match_a;
    flag_next[DTC_F_CMP_B] = flag_next[DTC_F_CMP_B] | match_b;
    flag_next[DTC_F_CAPTURE] = flag_next[DTC_F_CAPTURE] | cap_trig;
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      flag_reg <= DTC_FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // masked requests toward the interrupt controller
  assign TIMER_REQ_O = flag_reg & mask_reg;

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_reg <= 16'h0000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        DTC_CAPTURE_OFS: rdata_reg <= capture_reg;
        DTC_CMP_B_OFS: rdata_reg <= cmp_b_reg;
        DTC_CMP_A_OFS: rdata_reg <= cmp_a_reg;
        DTC_WIDE_VAL_OFS: rdata_reg <= wide_val_reg;
        DTC_CAP_CTRL_OFS: rdata_reg <= {8'h00, cap_ctrl_reg};
        DTC_CMP_CTRL_OFS: rdata_reg <= {8'h00, cmp_ctrl_reg};
        DTC_NARROW_VAL_OFS: rdata_reg <= {8'h00, narrow_val_reg};
        DTC_NARROW_CTRL_OFS: rdata_reg <= {8'h00, narrow_ctrl_reg};
        DTC_FLAG_OFS: rdata_reg <= {11'h000, flag_reg};
        DTC_MASK_OFS: rdata_reg <= {11'h000, mask_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign REG_RDATA_O = rdata_reg;
endmodule

// ---- core/dtc_pkg.sv ----
// Purpose: shared constants for the dual timer/counter unit
// Assumes: 16-bit register data port, 8-bit register address
// Notes: 8-bit registers sit in the low bits and read zero above
package dtc_pkg;
  // register byte offsets
  localparam logic [7:0] DTC_CAPTURE_OFS = 8'h24;
  localparam logic [7:0] DTC_CMP_B_OFS = 8'h28;
  localparam logic [7:0] DTC_CMP_A_OFS = 8'h2A;
  localparam logic [7:0] DTC_WIDE_VAL_OFS = 8'h2C;
  localparam logic [7:0] DTC_CAP_CTRL_OFS = 8'h2E;
  localparam logic [7:0] DTC_CMP_CTRL_OFS = 8'h2F;
  localparam logic [7:0] DTC_NARROW_VAL_OFS = 8'h32;
  localparam logic [7:0] DTC_NARROW_CTRL_OFS = 8'h33;
  localparam logic [7:0] DTC_FLAG_OFS = 8'h38;
  localparam logic [7:0] DTC_MASK_OFS = 8'h39;
  // reset values
  localparam logic [7:0] DTC_CTRL_RST = 8'h00;
  localparam logic [15:0] DTC_VAL_RST = 16'h0000;
  localparam logic [4:0] DTC_FLAG_RST = 5'h00;
  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] DTC_NARROW_CTRL_WMASK = 8'h07;
  localparam logic [7:0] DTC_CMP_CTRL_WMASK = 8'hF3;
  localparam logic [7:0] DTC_CAP_CTRL_WMASK = 8'hCF;
  // compare control field positions
  localparam int DTC_MODE_A_HI = 7;
  localparam int DTC_MODE_A_LO = 6;
  localparam int DTC_MODE_B_HI = 5;
  localparam int DTC_MODE_B_LO = 4;
  localparam int DTC_PWM_HI = 1;
  localparam int DTC_PWM_LO = 0;
  // capture control field positions
  localparam int DTC_FILT_EN = 7;
  localparam int DTC_EDGE_SEL = 6;
  localparam int DTC_CLR_ON_A = 3;
  localparam int DTC_CS_HI = 2;
  localparam int DTC_CS_LO = 0;
  // flag and mask bit positions
  localparam int DTC_F_NARROW_OVF = 0;
  localparam int DTC_F_WIDE_OVF = 1;
  localparam int DTC_F_CMP_A = 2;
  localparam int DTC_F_CMP_B = 3;
  localparam int DTC_F_CAPTURE = 4;
  localparam int DTC_FLAG_W = 5;
  // clock select codes
  localparam logic [2:0] DTC_CS_STOP = 3'h0;
  localparam logic [2:0] DTC_CS_CK = 3'h1;
  localparam logic [2:0] DTC_CS_DIV8 = 3'h2;
  localparam logic [2:0] DTC_CS_DIV64 = 3'h3;
  localparam logic [2:0] DTC_CS_DIV256 = 3'h4;
  localparam logic [2:0] DTC_CS_DIV1024 = 3'h5;
  localparam logic [2:0] DTC_CS_FALL = 3'h6;
  localparam logic [2:0] DTC_CS_RISE = 3'h7;
  localparam int DTC_PRE_W = 10;
  // compare output modes
  localparam logic [1:0] DTC_OM_OFF = 2'h0;
  localparam logic [1:0] DTC_OM_TOGGLE = 2'h1;
  localparam logic [1:0] DTC_OM_CLEAR = 2'h2;
  localparam logic [1:0] DTC_OM_SET = 2'h3;
  // pwm resolution codes and turning points
  localparam logic [1:0] DTC_PWM_OFF = 2'h0;
  localparam logic [1:0] DTC_PWM_8 = 2'h1;
  localparam logic [1:0] DTC_PWM_9 = 2'h2;
  localparam logic [1:0] DTC_PWM_10 = 2'h3;
  localparam logic [15:0] DTC_TOP_8 = 16'h00FF;
  localparam logic [15:0] DTC_TOP_9 = 16'h01FF;
  localparam logic [15:0] DTC_TOP_10 = 16'h03FF;
  localparam logic [15:0] DTC_WIDE_MAX = 16'hFFFF;
  localparam logic [7:0] DTC_NARROW_MAX = 8'hFF;
  // noise filter sample count
  localparam int DTC_FILT_SAMPLES = 4;
  // pwm count direction, one-hot
  typedef enum logic [1:0] {DTC_UP = 2'b01, DTC_DOWN = 2'b10} dtc_dir_t;
endpackage

// ---- core/dtc_clk_sel.sv ----
// Purpose: count tick selection from prescaler taps or a count pin
// Assumes: pre_i is a free running counter on clk_i
// Notes: pin edges need a level held at least one clock
`timescale 1ns/1ns
module dtc_clk_sel
  import dtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] sel_i,
  input wire logic [DTC_PRE_W-1:0] pre_i,
  input wire logic pin_i,
  output logic tick_o
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // two-stage pin synchroniser plus edge history
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // tick per clock select code, prescaled taps from the oscillator clock
  always_comb begin
    case (sel_i)
      DTC_CS_STOP: tick_o = 1'b0;
      DTC_CS_CK: tick_o = 1'b1;
      DTC_CS_DIV8: tick_o = &pre_i[2:0];
      DTC_CS_DIV64: tick_o = &pre_i[5:0];
      DTC_CS_DIV256: tick_o = &pre_i[7:0];
      DTC_CS_DIV1024: tick_o = &pre_i[9:0];
      DTC_CS_FALL: tick_o = prev_reg & ~sync2_reg;
      DTC_CS_RISE: tick_o = ~prev_reg & sync2_reg;
      default: tick_o = 1'b0;
    endcase
  end
endmodule

// ---- core/dtc_capture.sv ----
// Purpose: capture trigger with source select and noise filter
// Assumes: pin and comparator output are asynchronous to clk_i
// Notes: changing source or filter may raise one spurious trigger
`timescale 1ns/1ns
module dtc_capture
  import dtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic acmp_i,
  input wire logic acmp_sel_i,
  input wire logic filt_i,
  input wire logic edge_i,
  output logic trig_o
);
  logic pin1_reg;
  logic pin2_reg;
  logic acmp1_reg;
  logic acmp2_reg;
  logic [DTC_FILT_SAMPLES-1:0] hist_reg;
  logic flt_reg;
  logic lvl_prev_reg;
  logic src;
  logic lvl;

  // synchronise both sources
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin1_reg <= 1'b0;
      pin2_reg <= 1'b0;
      acmp1_reg <= 1'b0;
      acmp2_reg <= 1'b0;
    end else begin
      pin1_reg <= pin_i;
      pin2_reg <= pin1_reg;
      acmp1_reg <= acmp_i;
      acmp2_reg <= acmp1_reg;
    end
  end

  // source select
  assign src = acmp_sel_i ? acmp2_reg : pin2_reg;

  // filter: level moves only after four equal samples
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hist_reg <= '0;
      flt_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[DTC_FILT_SAMPLES-2:0], src};
      if (&hist_reg) begin
        flt_reg <= 1'b1;
      end else if (~|hist_reg) begin
        flt_reg <= 1'b0;
      end
    end
  end

  // selected level and its history
  assign lvl = filt_i ? flt_reg : src;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_prev_reg <= 1'b0;
    end else begin
      lvl_prev_reg <= lvl;
    end
  end

  // edge of the chosen polarity
  assign trig_o = edge_i ? (lvl & ~lvl_prev_reg) : (~lvl & lvl_prev_reg);
endmodule

// ---- sim/dtc_top_properties.sv ----
// Purpose: port-level checks for the dual timer/counter
// Assumes: bound to dtc_top, single clock domain
// Notes: register state is inferred from the bus writes seen at the ports
`timescale 1ns/1ns
module dtc_top_properties
  import dtc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic COMPARE_OUT_PIN_A_OE_O,
  input wire logic COMPARE_OUT_PIN_B_OE_O,
  input wire logic [DTC_FLAG_W-1:0] TIMER_REQ_O
);
  logic rd_n;
  logic rd_c;
  logic rd_p;
  logic wr_c;
  logic wr_m;
  // decoded strobes for the watched registers
  assign rd_n = REG_RD_I && REG_ADDR_I == DTC_NARROW_CTRL_OFS;
  assign rd_c = REG_RD_I && REG_ADDR_I == DTC_CMP_CTRL_OFS;
  assign rd_p = REG_RD_I && REG_ADDR_I == DTC_CAP_CTRL_OFS;
  assign wr_c = REG_WR_I && REG_ADDR_I == DTC_CMP_CTRL_OFS;
  assign wr_m = REG_WR_I && REG_ADDR_I == DTC_MASK_OFS;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
    else $error("read data not zero outside read cycle");
  // reserved control bits read zero
  narrow_rsvd_a: assert property ($past(rd_n) |-> REG_RDATA_O[15:3] == 13'h0000)
    else $error("narrow control reserved bits not zero");
  cmp_rsvd_a: assert property ($past(rd_c) |-> REG_RDATA_O[3:2] == 2'h0)
    else $error("compare control reserved bits not zero");
  cap_rsvd_a: assert property ($past(rd_p) |-> REG_RDATA_O[5:4] == 2'h0)
    else $error("capture control reserved bits not zero");
  // a cleared mask silences every request
  mask_off_a: assert property (
    wr_m && REG_WDATA_I[4:0] == 5'h00 |=> TIMER_REQ_O == 5'h00)
    else $error("request raised while masked");
  // mode 00 disconnects the compare pin
  oe_a_off_a: assert property (
    wr_c && REG_WDATA_I[7:6] == DTC_OM_OFF |=> !COMPARE_OUT_PIN_A_OE_O)
    else $error("pin a driven while disconnected");
  oe_b_off_a: assert property (
    wr_c && REG_WDATA_I[5:4] == DTC_OM_OFF |=> !COMPARE_OUT_PIN_B_OE_O)
    else $error("pin b driven while disconnected");
  // any other mode outside pwm drives the pin
  oe_a_on_a: assert property (
    wr_c && REG_WDATA_I[7:6] != 2'h0 && REG_WDATA_I[1:0] == 2'h0 |=> COMPARE_OUT_PIN_A_OE_O)
    else $error("pin a not driven");
  oe_b_on_a: assert property (
    wr_c && REG_WDATA_I[5:4] != 2'h0 && REG_WDATA_I[1:0] == 2'h0 |=> COMPARE_OUT_PIN_B_OE_O)
    else $error("pin b not driven");
endmodule

bind dtc_top dtc_top_properties i_props (
  .REF_CLK_I(REF_CLK_I),
  .RSTN_I(RSTN_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O),
  .COMPARE_OUT_PIN_A_OE_O(COMPARE_OUT_PIN_A_OE_O),
  .COMPARE_OUT_PIN_B_OE_O(COMPARE_OUT_PIN_B_OE_O),
  .TIMER_REQ_O(TIMER_REQ_O)
);

// ---- sim/dtc_top_tb.sv ----
// Purpose: register-level bench for the dual timer/counter
// Assumes: read data stand in the cycle after the read strobe
// Notes: counts are timed by reading a counter a fixed number of cycles apart
`timescale 1ns/1ns
module dtc_top_tb
  import dtc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic npin = 1'b0;
  logic wpin = 1'b0;
  logic cpin = 1'b0;
  logic acmp = 1'b0;
  logic acmp_en = 1'b0;
  logic [15:0] rdata;
  logic pa, pa_oe, pb, pb_oe;
  logic [4:0] req;
  logic [15:0] v0, v1, cap;
  logic [7:0] ca, va;
  int n, m;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] rst_a [5] = '{8'h2E, 8'h2F, 8'h32, 8'h33, 8'h01};
  logic [7:0] rsv_a [3] = '{8'h33, 8'h2F, 8'h2E};
  logic [7:0] rsv_m [3] = '{8'h07, 8'hF3, 8'hCF};
  int div [6] = '{8, 1, 8, 64, 256, 1024};
  int top [4] = '{0, 255, 511, 1023};
  // capture rows: control, source select, line, pulse length, capture expected
  int cc [9] = '{64, 64, 0, 0, 192, 192, 64, 64, 64};
  int ce [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  int cl [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  int cn [9] = '{0, 0, 0, 0, 2, 8, 2, 8, 8};
  int ex [9] = '{1, 0, 0, 1, 0, 1, 1, 0, 1};

  dtc_top i_dut (
    .REF_CLK_I(clk),
    .RSTN_I(rst_n),
    .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata),
    .REG_WR_I(wr),
    .REG_RD_I(rd),
    .REG_RDATA_O(rdata),
    .NARROW_COUNT_PIN_I(npin),
    .WIDE_COUNT_PIN_I(wpin),
    .CAPTURE_INPUT_PIN_I(cpin),
    .COMPARATOR_OUTPUT_I(acmp),
    .COMPARATOR_CAPTURE_ENABLE_I(acmp_en),
    .COMPARE_OUT_PIN_A_O(pa),
    .COMPARE_OUT_PIN_A_OE_O(pa_oe),
    .COMPARE_OUT_PIN_B_O(pb),
    .COMPARE_OUT_PIN_B_OE_O(pb_oe),
    .TIMER_REQ_O(req)
  );

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one read strobe, data taken once the answer has settled
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // cycles until compare pin a changes, bounded
  task automatic wait_chg(output int k);
    logic last;
    last = pa;
    k = 0;
    while (pa === last) begin
      @(posedge clk);
      #1 k++;
      if (k > 3000) begin
        miscompares++;
        give_verdict();
      end
    end
  endtask

  // five toggles of one count pin, each level held two clocks
  task automatic pins(input bit w);
    repeat (5) begin
      repeat (2) @(posedge clk);
      wpin <= w ? ~wpin : wpin;
      npin <= w ? npin : ~npin;
    end
  endtask

  initial begin
    cap = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped address
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i], v0);
      chk("reset value", v0, 16'h0000);
    end
    // reserved control bits ignore writes
    for (int i = 0; i < 3; i++) begin
      wr_reg(rsv_a[i], 16'hFFFF);
      rd_reg(rsv_a[i], v0);
      chk("control bits", v0, {8'h00, rsv_m[i]});
      wr_reg(rsv_a[i], 16'h0000);
    end
    // every clock select code on both counters
    for (int c = 0; c < 2; c++) begin
      ca = c ? DTC_CAP_CTRL_OFS : DTC_NARROW_CTRL_OFS;
      va = c ? DTC_WIDE_VAL_OFS : DTC_NARROW_VAL_OFS;
      for (int s = 0; s < 6; s++) begin
        wr_reg(ca, 16'(s));
        rd_reg(va, v0);
        repeat (2 * div[s] - 2) @(posedge clk);
        rd_reg(va, v1);
        chk("prescaled count", v1 - v0, s ? 16'h0002 : 16'h0000);
      end
      for (int s = 6; s < 8; s++) begin
        @(posedge clk);
        npin <= 1'b0;
        wpin <= 1'b0;
        wr_reg(ca, 16'(s));
        repeat (6) @(posedge clk);
        rd_reg(va, v0);
        pins(c);
        repeat (6) @(posedge clk);
        rd_reg(va, v1);
        chk("pin count", v1 - v0, s == 6 ? 16'h0002 : 16'h0003);
      end
      wr_reg(ca, 16'h0000);
    end
    // narrow wrap raises its flag and, with its mask bit set, its request
    wr_reg(DTC_MASK_OFS, 16'h0001);
    wr_reg(DTC_NARROW_VAL_OFS, 16'h00FE);
    wr_reg(DTC_FLAG_OFS, 16'h001F);
    rd_reg(DTC_FLAG_OFS, v0);
    chk("flags cleared", v0, 16'h0000);
    wr_reg(DTC_NARROW_CTRL_OFS, 16'h0001);
    repeat (8) @(posedge clk);
    wr_reg(DTC_NARROW_CTRL_OFS, 16'h0000);
    rd_reg(DTC_FLAG_OFS, v0);
    chk("overflow flag", v0, 16'h0001);
    chk("request", {11'h000, req}, 16'h0001);
    wr_reg(DTC_MASK_OFS, 16'h0000);
    wr_reg(DTC_FLAG_OFS, 16'h001F);
    // match a toggles pin a and clears, match b sets then clears pin b
    wr_reg(DTC_CMP_A_OFS, 16'h0005);
    wr_reg(DTC_CMP_B_OFS, 16'h0003);
    wr_reg(DTC_WIDE_VAL_OFS, 16'h0000);
    wr_reg(DTC_CMP_CTRL_OFS, 16'h0070);
    wr_reg(DTC_CAP_CTRL_OFS, 16'h0009);
    wait_chg(n);
    wait_chg(n);
    chk("toggle period", 16'(n), 16'h0006);
    chk("pin b set", {15'h0000, pb}, 16'h0001);
    wr_reg(DTC_CMP_CTRL_OFS, 16'h0060);
    repeat (8) @(posedge clk);
    chk("pin b clear", {15'h0000, pb}, 16'h0000);
    rd_reg(DTC_FLAG_OFS, v0);
    chk("match flags", v0 & 16'h000E, 16'h000C);
    // pwm period is twice the top value
    wr_reg(DTC_CMP_A_OFS, 16'h0010);
    for (int p = 1; p < 4; p++) begin
      wr_reg(DTC_CMP_CTRL_OFS, (p == 3 ? 16'h00C0 : 16'h0080) | 16'(p));
      wait_chg(n);
      wait_chg(n);
      wait_chg(m);
      chk("pwm period", 16'(n + m), 16'(2 * top[p]));
      chk("pwm drive", {15'h0000, pa_oe}, 16'h0001);
    end
    wr_reg(DTC_CMP_CTRL_OFS, 16'h0000);
    // bottom turns in pwm raised the wide overflow flag
    rd_reg(DTC_FLAG_OFS, v0);
    chk("wide overflow", v0 & 16'h0002, 16'h0002);
    // capture edges, filter and source, counter stopped
    for (int r = 0; r < 9; r++) begin
      wr_reg(DTC_CAP_CTRL_OFS, 16'(cc[r]));
      wr_reg(DTC_WIDE_VAL_OFS, 16'h1000 + 16'(r));
      @(posedge clk);
      acmp_en <= ce[r][0];
      repeat (8) @(posedge clk);
      wr_reg(DTC_FLAG_OFS, 16'h001F);
      @(posedge clk);
      cpin <= cl[r] ? cpin : (cn[r] == 0 ? ~cpin : 1'b1);
      acmp <= cl[r][0];
      // pulse rows end later, toggle rows keep their new level
      if (cn[r] > 0) begin
        repeat (cn[r]) @(posedge clk);
        cpin <= 1'b0;
        acmp <= 1'b0;
      end
      repeat (10) @(posedge clk);
      rd_reg(DTC_FLAG_OFS, v0);
      chk("capture flag", 16'(v0[4]), 16'(ex[r]));
      cap = ex[r] ? 16'h1000 + 16'(r) : cap;
      rd_reg(DTC_CAPTURE_OFS, v1);
      chk("capture value", v1, cap);
    end
    give_verdict();
  end
endmodule
